// ### core/rf_ctl_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RF_CTL_REGS_SVH
`define RF_CTL_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_POWER     8'h04
`define REG_FUNC      8'h08
`define REG_GPIO      8'h0c
`define REG_CHAN      8'h10
`define REG_STATUS    8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_CAP_BIT  0
`define CTRL_NCD_BIT  1
`define ST_TX_BIT     0
`define ST_RX_BIT     1
`define ST_PA_BIT     2
`define ST_RDY_BIT    3
`define ST_REJ_BIT    4
`define ST_BLK_BIT    5

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define PWR_MAX       5'h11
`define PWR_CAP_HI    5'h07
`define PWR_CAP_EXTRA 5'h0c
`define PWR_RST       5'h0c
`define CHAN_BLOCKED  5'h1a
`define CHAN_RST      5'h0b

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ       10
`define TX_WARM_US    60
`define RX_WARM_US    72
`define TX_WARM_CYC   (`TX_WARM_US * `CLK_MHZ)
`define RX_WARM_CYC   (`RX_WARM_US * `CLK_MHZ)

`endif

// ### core/rf_ctl_pkg.sv
// Types shared by the RF front-end control block
package rf_ctl_pkg;

   // ------------------------------------------------------------
   // Bus request carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic        cyc;   // Cycle
      logic        stb;   // Strobe
      logic        we;    // Write
      logic [7:0]  adr;   // Byte address
      logic [31:0] dat;   // Write data
      logic [3:0]  sel;   // Byte lanes
   } wb_req_t;

   // ------------------------------------------------------------
   // Radio sequencer states, Gray along the TX path except the ST_TX_WARM to ST_TX_DOWN abort
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_TX_WARM = 3'h1,
      ST_TX_RUN  = 3'h3,
      ST_TX_DOWN = 3'h2,
      ST_RX_WARM = 3'h6,
      ST_RX_RUN  = 3'h7
   } radio_state_t;

   // ------------------------------------------------------------
   // Pin function codes; code 3 behaves as plain GPIO
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FN_GPIO = 2'h0,
      FN_TX   = 2'h1,
      FN_RX   = 2'h2,
      FN_RSVD = 2'h3
   } pin_fn_t;

endpackage : rf_ctl_pkg

// ### core/rf_frontend_control_outputs.sv
// RF front-end control outputs, power level and demodulator mode
// Functional notes
// - Power codes 0..0x11; cap allows 0..7, C
// - Cap mode blocks channel 26 entirely
// - Cap mode off after reset
// - Demodulator: chip detect default, noncoherent optional
// - Antenna pins: 00 GPIO, 01 sequencer
// - Enable pins: 00 GPIO, 01 TX, 10 RX
// - TX enable: rest 0 on TX, 1 on RX
// - RX enable: rest 1 on TX, 0 on RX
// - Antenna A low only during receive
// - Antenna B low only during transmit
// - Control asserts when TX sequencer starts
// - TX warm-up 60 us before PA ramp
// - TX control drops when sequencer idles
// - Control asserts when RX sequencer starts
// - RX warm-up 72 us before ready
// - RX control drops when sequencer idles
// - Each transmit waits for VCO lock
// - Low power: pins float as inputs
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "rf_ctl_regs.svh"

module rf_frontend_control_outputs
   import rf_ctl_pkg::*;
(
   input  wire logic        clock,        // 10 MHz clock
   input  wire logic        sys_rst,      // Sync reset
   input  wire logic        ce,           // Clock enable
   input  wire wb_req_t     wb_req,       // Bus request
   output logic [31:0]      wb_dat_o,     // Read data
   output logic             wb_ack_o,     // Acknowledge
   input  wire logic        tx_req,       // Transmit request
   input  wire logic        rx_req,       // Receive or CCA request
   input  wire logic        vco_lock,     // VCO locked
   input  wire logic        low_power,    // Low-power mode
   input  wire logic [3:0]  pin_in,       // Pin levels
   output logic [3:0]       pin_out,      // Pin drive values
   output logic [3:0]       pin_oe,       // Pin drive enables
   output logic             vco_en,       // VCO enable
   output logic             pa_ramp,      // PA at selected power
   output logic             rx_ready,     // Receiver ready
   output logic [4:0]       power_level,  // Power level code
   output logic             demod_ncd,    // Noncoherent detect mode
   output logic             tx_active,    // TX sequencer active
   output logic             rx_active     // RX sequencer active
);

   // ---------------------------------------------------------------
   // Constants
   // ---------------------------------------------------------------
   localparam logic [9:0] TX_LAST = 10'(`TX_WARM_CYC - 1);  // Last TX warm count
   localparam logic [9:0] RX_LAST = 10'(`RX_WARM_CYC - 1);  // Last RX warm count

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Code allowed under the current cap setting
   function automatic logic level_ok(input logic [4:0] code, input logic cap);
      level_ok = (code <= `PWR_MAX) &&
                 (!cap || code <= `PWR_CAP_HI || code == `PWR_CAP_EXTRA);
   endfunction : level_ok

   // Sequencer drive {control, value} for one pin
   function automatic logic [1:0] pin_ctl(input int idx, input pin_fn_t fn,
                                          input logic tx, input logic rx);
      logic [1:0] r;
      r = 2'h0;
      unique case (idx)
         0: r = {fn == FN_TX, ~rx};
         1: r = {fn == FN_TX, ~tx};
         2: r = {fn == FN_TX || fn == FN_RX,
                 (fn == FN_TX) ? tx : ~rx};
         default: r = {fn == FN_TX || fn == FN_RX,
                       (fn == FN_TX) ? ~tx : rx};
      endcase
      return r;
   endfunction : pin_ctl

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic          cap_q;        // Power cap mode
   logic          ncd_q;        // Demodulator mode
   logic [4:0]    level_q;      // Power level
   pin_fn_t       fn_q [4];     // Pin functions
   logic [3:0]    gpo_q;        // GPIO values
   logic [3:0]    gpoe_q;       // GPIO enables
   logic [4:0]    chan_q;       // Channel number
   logic          rej_q;        // Rejected level write
   logic          blk_q;        // Blocked channel request
   logic          ack_q;        // Bus acknowledge
   logic [31:0]   dat_q;        // Read data
   radio_state_t  state_q;      // Sequencer state
   radio_state_t  state_d;      // Next state
   logic [9:0]    cnt_q;        // Warm-up counter
   logic [3:0]    pout_q;       // Pin values
   logic [3:0]    poe_q;        // Pin enables
   logic          wr;           // Write commits
   logic          wr_lvl_bad;   // Rejected level write
   logic          chan_block;   // Start is blocked
   logic          tx_d;         // Next TX active
   logic          rx_d;         // Next RX active
   logic [31:0]   rd;           // Read mux

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   // Write takes effect on the edge that the master sees ack
   assign wr = wb_req.cyc && wb_req.stb && wb_req.we && ack_q && wb_req.sel[0];

   // Ack one cycle after strobe, dropped the next cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ack_q <= 1'h0;
      end else if (ce) begin
         ack_q <= wb_req.cyc && wb_req.stb && !ack_q;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd = 32'h0;
      unique case (wb_req.adr)
         `REG_CTRL:   rd = {30'h0, ncd_q, cap_q};
         `REG_POWER:  rd = {27'h0, level_q};
         `REG_FUNC:   rd = {24'h0, fn_q[3], fn_q[2], fn_q[1], fn_q[0]};
         `REG_GPIO:   rd = {20'h0, pin_in, gpoe_q, gpo_q};
         `REG_CHAN:   rd = {27'h0, chan_q};
         `REG_STATUS: rd = {26'h0, blk_q, rej_q, rx_ready, pa_ramp,
                            rx_active, tx_active};
         default:     rd = 32'h0;
      endcase
   end

   // Read data captured with the ack
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dat_q <= 32'h0;
      end else if (ce && wb_req.cyc && wb_req.stb && !ack_q) begin
         dat_q <= rd;
      end
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   // Cap and demodulator mode, both off at reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cap_q <= 1'h0;
         ncd_q <= 1'h0;
      end else if (ce && wr && wb_req.adr == `REG_CTRL) begin
         cap_q <= wb_req.dat[`CTRL_CAP_BIT];
         ncd_q <= wb_req.dat[`CTRL_NCD_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Power level
   // ---------------------------------------------------------------
   assign wr_lvl_bad = wr && wb_req.adr == `REG_POWER &&
                       !level_ok(wb_req.dat[4:0], cap_q);

   // Level kept on reject; clamped when cap turns on over it
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         level_q <= `PWR_RST;
      end else if (ce) begin
         if (wr && wb_req.adr == `REG_POWER && !wr_lvl_bad) begin
            level_q <= wb_req.dat[4:0];
         end else if (cap_q && !level_ok(level_q, 1'h1)) begin
            level_q <= `PWR_CAP_EXTRA;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin function, GPIO and channel registers
   // ---------------------------------------------------------------
   // Function codes, GPIO by default
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fn_q <= '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO};
      end else if (ce && wr && wb_req.adr == `REG_FUNC) begin
         for (int i = 0; i < 4; i++) begin
            fn_q[i] <= pin_fn_t'(wb_req.dat[2*i +: 2]);
         end
      end
   end

   // Plain GPIO drive
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gpo_q  <= 4'h0;
         gpoe_q <= 4'h0;
      end else if (ce && wr && wb_req.adr == `REG_GPIO) begin
         gpo_q  <= wb_req.dat[3:0];
         gpoe_q <= wb_req.dat[7:4];
      end
   end

   // Channel number
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         chan_q <= `CHAN_RST;
      end else if (ce && wr && wb_req.adr == `REG_CHAN) begin
         chan_q <= wb_req.dat[4:0];
      end
   end

   // ---------------------------------------------------------------
   // Sticky status flags, set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rej_q <= 1'h0;
         blk_q <= 1'h0;
      end else if (ce) begin
         rej_q <= (rej_q && !(wr && wb_req.adr == `REG_STATUS &&
                   wb_req.dat[`ST_REJ_BIT])) || wr_lvl_bad;
         blk_q <= (blk_q && !(wr && wb_req.adr == `REG_STATUS &&
                   wb_req.dat[`ST_BLK_BIT])) ||
                  (state_q == ST_IDLE && chan_block);
      end
   end

   // ---------------------------------------------------------------
   // Radio sequencer
   // ---------------------------------------------------------------
   // Any request on channel 26 under cap is refused
   assign chan_block = cap_q && chan_q == `CHAN_BLOCKED && (tx_req || rx_req);

   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (tx_req && !chan_block) begin
               state_d = ST_TX_WARM;
            end else if (rx_req && !chan_block) begin
               state_d = ST_RX_WARM;
            end
         end
         ST_TX_WARM: begin
            if (!tx_req) begin
               state_d = ST_TX_DOWN;
            end else if (cnt_q >= TX_LAST && vco_lock) begin
               state_d = ST_TX_RUN;
            end
         end
         ST_TX_RUN: begin
            if (!tx_req) begin
               state_d = ST_TX_DOWN;
            end
         end
         ST_TX_DOWN: state_d = ST_IDLE;
         ST_RX_WARM: begin
            if (!rx_req) begin
               state_d = ST_IDLE;
            end else if (cnt_q >= RX_LAST) begin
               state_d = ST_RX_RUN;
            end
         end
         ST_RX_RUN: begin
            if (!rx_req) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // Warm-up counter, saturating, cleared outside warm-up
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_q <= 10'h0;
      end else if (ce) begin
         if (state_q != ST_TX_WARM && state_q != ST_RX_WARM) begin
            cnt_q <= 10'h0;
         end else if (cnt_q != 10'h3ff) begin
            cnt_q <= cnt_q + 10'h1;
         end
      end
   end

   assign tx_d        = state_d inside {ST_TX_WARM, ST_TX_RUN, ST_TX_DOWN};
   assign rx_d        = state_d inside {ST_RX_WARM, ST_RX_RUN};
   assign tx_active   = state_q inside {ST_TX_WARM, ST_TX_RUN, ST_TX_DOWN};
   assign rx_active   = state_q inside {ST_RX_WARM, ST_RX_RUN};
   assign vco_en      = tx_active || rx_active;
   assign pa_ramp     = state_q == ST_TX_RUN;
   assign rx_ready    = state_q == ST_RX_RUN;
   assign power_level = level_q;
   assign demod_ncd   = ncd_q;

   // ---------------------------------------------------------------
   // Pin drivers, aligned with the state register
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_pin
      logic [1:0] c;                                      // {control, value}
      assign c = pin_ctl(g, fn_q[g], tx_d, rx_d);
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            pout_q[g] <= 1'h0;
            poe_q[g]  <= 1'h0;
         end else if (ce) begin
            pout_q[g] <= c[1] ? c[0] : gpo_q[g];
            poe_q[g]  <= c[1] || gpoe_q[g];
         end
      end
   end

   // Low power releases every pin at once
   assign pin_out = pout_q;
   assign pin_oe  = low_power ? 4'h0 : poe_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_level_range: assert property (@(posedge clock) disable iff (sys_rst)
      level_q <= `PWR_MAX) else $error("power level above top code");
   a_cap_level: assert property (@(posedge clock) disable iff (sys_rst)
      cap_q && ce && !wr |=> level_ok(level_q, 1'h1))
      else $error("capped level not allowed");
   a_chan_block: assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_IDLE && chan_block |=> state_q == ST_IDLE)
      else $error("blocked channel started");
   a_reset_modes: assert property (@(posedge clock)
      sys_rst |=> !cap_q && !ncd_q) else $error("modes not off after reset");
   a_txen_tx: assert property (@(posedge clock) disable iff (sys_rst)
      fn_q[2] == FN_TX && $stable(fn_q[2]) |-> pout_q[2] == tx_active)
      else $error("tx enable wrong in tx mode");
   a_rxen_rx: assert property (@(posedge clock) disable iff (sys_rst)
      fn_q[3] == FN_RX && $stable(fn_q[3]) |-> pout_q[3] == rx_active)
      else $error("rx enable wrong in rx mode");
   a_ant_a_rx: assert property (@(posedge clock) disable iff (sys_rst)
      fn_q[0] == FN_TX && $stable(fn_q[0]) |-> pout_q[0] == !rx_active)
      else $error("antenna a wrong");
   a_ant_b_tx: assert property (@(posedge clock) disable iff (sys_rst)
      fn_q[1] == FN_TX && $stable(fn_q[1]) |-> pout_q[1] == !tx_active)
      else $error("antenna b wrong");
   a_tx_warm_len: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(pa_ramp) |-> $past(cnt_q) >= TX_LAST && $past(vco_lock))
      else $error("pa ramped early");
   a_rx_warm_len: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(rx_ready) |-> $past(cnt_q) >= RX_LAST)
      else $error("receiver ready early");
   a_tx_drop: assert property (@(posedge clock) disable iff (sys_rst)
      $fell(tx_active) |-> $past(state_q) == ST_TX_DOWN && !pa_ramp)
      else $error("tx dropped before pa down");
   a_low_power: assert property (@(posedge clock) disable iff (sys_rst)
      low_power |-> pin_oe == 4'h0) else $error("pin driven in low power");

   c_tx_run: cover property (@(posedge clock) disable iff (sys_rst)
      $rose(pa_ramp));
   c_rx_run: cover property (@(posedge clock) disable iff (sys_rst)
      $rose(rx_ready));
   c_reject: cover property (@(posedge clock) disable iff (sys_rst)
      $rose(rej_q));
   c_block: cover property (@(posedge clock) disable iff (sys_rst)
      $rose(blk_q));

endmodule : rf_frontend_control_outputs
`default_nettype wire

// ### sim/frontend_model.sv
// External front-end model: wire levels of the pulled-down control pins
`timescale 1ns/10ps
`default_nettype none

module frontend_model (
   input  wire logic [3:0] pin_out,  // Drive values from the block
   input  wire logic [3:0] pin_oe,   // Drive enables from the block
   output logic      [3:0] pin_in    // Resolved wire levels
);
   // ------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------
   // A released pin sinks to the board pull-down, never keeps its last value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : 1'b0;
      end
   end
endmodule : frontend_model

`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the RF front-end control block
`timescale 1ns/10ps
`default_nettype none
`include "rf_ctl_regs.svh"

module tb_top
   import rf_ctl_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clock, sys_rst, ce, tx_req, rx_req, vco_lock, low_power;  // Stimulus
   wb_req_t     wb_req;                                           // Bus request
   logic [31:0] wb_dat_o, rd;                                     // Read data
   logic        wb_ack_o, vco_en, pa_ramp, rx_ready;              // Status outputs
   logic        demod_ncd, tx_active, rx_active;                  // Mode and state
   logic [3:0]  pin_in, pin_out, pin_oe;                          // Control pins
   logic [4:0]  power_level;                                      // Level code
   int          fails, checked;                                   // Counters

   rf_frontend_control_outputs rf_frontend_control_outputs_inst (
      .clock(clock), .sys_rst(sys_rst), .ce(ce), .wb_req(wb_req),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_req(tx_req), .rx_req(rx_req),
      .vco_lock(vco_lock), .low_power(low_power), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .vco_en(vco_en), .pa_ramp(pa_ramp), .rx_ready(rx_ready),
      .power_level(power_level), .demod_ncd(demod_ncd), .tx_active(tx_active),
      .rx_active(rx_active));

   frontend_model frontend_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // Counts, verdict, stop
   task automatic end_of_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // Settle just after an edge
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick

   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      wb_req <= '{1'b1, 1'b1, w, a, d, 4'hf};
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_req <= '0;
      if (n >= 20) begin
         fails++;
         end_of_test();
      end
      @(posedge clock);
   endtask : wb

   // Read and compare
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rchk

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset values, GPIO mode, pin release in low power
   task automatic t_reset();
      rchk("ctrl", `REG_CTRL, 32'h0);
      rchk("power", `REG_POWER, {27'h0, `PWR_RST});
      rchk("func", `REG_FUNC, 32'h0);
      rchk("unmapped", 8'h40, 32'h0);
      chk("demod", 1'b0, demod_ncd);
      wb(1'b1, `REG_GPIO, 32'hff);
      tick();
      chk("gpio pins", 4'hf, pin_out);
      rchk("gpio read", `REG_GPIO, 32'hfff);
      @(posedge clock);
      low_power <= 1'b1;
      tick();
      chk("lp oe", 4'h0, pin_oe);
      rchk("lp wire", `REG_GPIO, 32'h0ff);
      @(posedge clock);
      low_power <= 1'b0;
      // Antenna code 10 and enable code 11 fall back to plain GPIO
      wb(1'b1, `REG_FUNC, 32'hfa);
      wb(1'b1, `REG_GPIO, 32'hf0);
      tick();
      chk("spare codes", 4'h0, pin_out);
      chk("spare oe", 4'hf, pin_oe);
      $display("test reset done");
   endtask : t_reset

   // Level codes, cap mode, blocked channel, demodulator mode
   task automatic t_power();
      logic [4:0] code[4] = '{5'h08, 5'h07, 5'h0c, 5'h0d};
      logic [4:0] exp_l[4] = '{5'h0c, 5'h07, 5'h0c, 5'h0c};
      wb(1'b1, `REG_POWER, 32'h11);
      chk("max level", 5'h11, power_level);
      wb(1'b1, `REG_POWER, 32'h12);
      chk("bad level", 5'h11, power_level);
      rchk("reject flag", `REG_STATUS, 32'h10);
      wb(1'b1, `REG_STATUS, 32'h30);
      wb(1'b1, `REG_CTRL, 32'h1);
      tick();
      chk("cap level", 5'h0c, power_level);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `REG_POWER, {27'h0, code[i]});
         chk("cap code", exp_l[i], power_level);
      end
      wb(1'b1, `REG_CHAN, 32'h1a);
      @(posedge clock);
      rx_req <= 1'h1;
      tx_req <= 1'h1;
      repeat (3) tick();
      chk("blocked rx", 1'h0, rx_active);
      chk("blocked tx", 1'h0, tx_active);
      rchk("block flag", `REG_STATUS, 32'h30);
      @(posedge clock);
      rx_req <= 1'h0;
      tx_req <= 1'h0;
      wb(1'b1, `REG_CTRL, 32'h2);
      chk("ncd", 1'b1, demod_ncd);
      wb(1'b1, `REG_CHAN, 32'h0b);
      $display("test power done");
   endtask : t_power

   // One transmission, lock early or late
   task automatic t_tx(input logic early);
      int n;
      wb(1'b1, `REG_FUNC, 32'h55);
      tick();
      chk("tx rest", 4'hb, pin_out);
      @(posedge clock);
      vco_lock <= early;
      tx_req <= 1'b1;
      tick();
      chk("tx start", 1'b1, tx_active);
      chk("tx pins", 4'h5, pin_out);
      chk("tx oe", 4'hf, pin_oe);
      chk("vco on", 1'b1, vco_en);
      n = 1;
      while (pa_ramp !== 1'b1 && n < 700) begin
         tick();
         n++;
      end
      if (early) begin
         chk("tx warm", 1'b1, n >= 598 && n <= 603);
      end else begin
         chk("tx no lock", 1'b0, pa_ramp);
         // Lock arrives while the clock enable is low: nothing may move
         @(posedge clock);
         vco_lock <= 1'h1;
         ce <= 1'h0;
         repeat (3) tick();
         chk("tx freeze", 1'h0, pa_ramp);
         @(posedge clock);
         ce <= 1'h1;
         repeat (3) tick();
         chk("tx lock", 1'b1, pa_ramp);
      end
      @(posedge clock);
      tx_req <= 1'b0;
      vco_lock <= 1'b0;
      tick();
      chk("tx down", 1'b0, pa_ramp);
      chk("tx hold", 4'h5, pin_out);
      tick();
      chk("tx idle", 1'b0, tx_active);
      chk("tx end", 4'hb, pin_out);
      $display("test tx done");
   endtask : t_tx

   // One reception with enables on RX codes
   task automatic t_rx();
      int n;
      wb(1'b1, `REG_FUNC, 32'ha5);
      tick();
      chk("rx rest", 4'h7, pin_out);
      @(posedge clock);
      rx_req <= 1'b1;
      tick();
      chk("rx start", 1'b1, rx_active);
      chk("rx pins", 4'ha, pin_out);
      n = 1;
      while (rx_ready !== 1'b1 && n < 800) begin
         tick();
         n++;
      end
      chk("rx warm", 1'b1, n >= 718 && n <= 723);
      @(posedge clock);
      rx_req <= 1'b0;
      tick();
      chk("rx idle", 1'b0, rx_active);
      chk("rx end", 4'h7, pin_out);
      $display("test rx done");
   endtask : t_rx

   // ------------------------------------------------------------
   // Clock and main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      fails = 0;
      checked = 0;
      sys_rst = 1'b1;
      tx_req = 1'b0;
      rx_req = 1'b0;
      vco_lock = 1'b0;
      low_power = 1'b0;
      ce = 1'h1;
      wb_req = '0;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_power();
      t_tx(1'b1);
      t_tx(1'b0);
      t_rx();
      end_of_test();
   end
endmodule : tb_top

`default_nettype wire
